// ==== odtc_pkg.sv ====
// odtc_pkg: constants, command codes and latency helpers shared by both
// termination link ends. assumes one 20 MHz clock drives both ends.
package odtc_pkg;

  // clock and asynchronous termination delays, in picoseconds
  localparam int CLK_PS       = 50000;
  localparam int ASYNC_MIN_PS = 2000;
  localparam int ASYNC_MAX_PS = 8500;
  // least time rounds up, longest rounds down, never under one cycle
  localparam int ASYNC_MIN_CYC_RAW = (ASYNC_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam int ASYNC_MAX_CYC_RAW = ASYNC_MAX_PS / CLK_PS;
  localparam int ASYNC_MIN_CYC = (ASYNC_MIN_CYC_RAW < 1) ? 1 : ASYNC_MIN_CYC_RAW;
  localparam int ASYNC_MAX_CYC = (ASYNC_MAX_CYC_RAW < 1) ? 1 : ASYNC_MAX_CYC_RAW;

  // hold intervals and burst shapes, in clocks
  localparam logic [7:0] SHORT_HOLD   = 8'h04;
  localparam logic [7:0] LONG_HOLD    = 8'h06;
  localparam logic [4:0] SYNC_LAT_OFS = 5'h02;
  localparam logic [7:0] BL8_CLK      = 8'h04;
  localparam logic [7:0] BC4_CLK      = 8'h02;
  localparam logic [7:0] POSTAMBLE    = 8'h01;

  // register byte offsets on the software bus
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_LAT    = 4'h4;
  localparam logic [3:0] REG_CMD    = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;

  // control register fields
  localparam int CTRL_ODT     = 0;
  localparam int CTRL_CKE     = 1;
  localparam int CTRL_DLL_SEL = 2;
  localparam int CTRL_NOM_EN  = 3;
  localparam int CTRL_WR_EN   = 4;
  localparam int CTRL_DLL_RST = 5;
  // latency register fields, four bits each
  localparam int LAT_CWL = 0;
  localparam int LAT_AL  = 4;
  localparam int LAT_CL  = 8;
  // command register fields
  localparam int CMD_CODE = 0;
  localparam int CMD_CHOP = 2;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
  localparam logic [3:0]  CWL_RESET  = 4'h5;
  localparam logic [3:0]  AL_RESET   = 4'h0;
  localparam logic [3:0]  CL_RESET   = 4'h6;

  typedef enum logic [1:0] {ODTC_NOP, ODTC_WRITE, ODTC_READ, ODTC_REFRESH} odtc_cmd_t;

  // write latency is cas write latency plus additive latency
  function automatic logic [4:0] odtc_write_latency(input logic [3:0] cas_write_latency,
                                                    input logic [3:0] al);
    odtc_write_latency = 5'(cas_write_latency) + 5'(al);
  endfunction : odtc_write_latency

  // synchronous on and off latency, identical for both edges
  function automatic logic [4:0] odtc_sync_latency(input logic [3:0] cas_write_latency,
                                                   input logic [3:0] al);
    odtc_sync_latency = odtc_write_latency(cas_write_latency, al) - SYNC_LAT_OFS;
  endfunction : odtc_sync_latency

endpackage : odtc_pkg

// ==== odtc_link_if.sv ====
// odtc_link_if: the pins between controller and memory device.
// assumes both ends sample on the same clk_sys edge.
`timescale 1ns/1ps
`default_nettype none
interface odtc_link_if;
  import odtc_pkg::*;
  logic       odt;
  logic       cke;
  odtc_cmd_t  cmd;
  logic       chop;
  logic [3:0] cas_write_latency;
  logic [3:0] al;
  logic       dll_pd_sel;
  logic       nom_en;
  logic       wr_en;
  logic       dll_reset;

  modport ctrl (output odt, cke, cmd, chop, cas_write_latency, al, dll_pd_sel, nom_en, wr_en, dll_reset);
  modport dram (input  odt, cke, cmd, chop, cas_write_latency, al, dll_pd_sel, nom_en, wr_en, dll_reset);
endinterface : odtc_link_if
`default_nettype wire

// ==== odtc_hold_timer.sv ====
// odtc_hold_timer: loadable down-counter that reports when it has run out.
// assumes load values are already in clocks.
`timescale 1ns/1ps
`default_nettype none
module odtc_hold_timer (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  output logic            idle
);
  import odtc_pkg::*;

  logic [7:0] count;
  logic [7:0] next_count;

  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_val;
    end else if (count != 8'h00) begin
      next_count = count - 8'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 8'h00;
    end else begin
      count <= next_count;
    end
  end

  assign idle = (count == 8'h00);
endmodule : odtc_hold_timer
`default_nettype wire

// ==== odtc_ctrl_end.sv ====
// odtc_ctrl_end: controller end that drives odt, cke and commands to the
// memory device, ordered by software over avalon-mm with waitrequest.
// assumes the device registers the link pins on the next clk_sys edge.
// Summary of operation
// [R1] odt stays high short hold after assertion
// [R2] write with odt high extends hold
// [R3] holds run from registration until odt low
// [R4] odt drops only after both holds end
// [R5] termination off before read preamble
// [R6] no re-enable before read postamble ends
// [R7] dll-off power-down selects asynchronous odt
// [R8] odt asynchronous while dll resynchronizes
// [R9] asynchronous path ignores additive latency
// [R10] async turn-on between 2 and 8.5 ns
// [R11] async turn-off between 2 and 8.5 ns
// [R12] entry transition only with dll off select
// [R13] entry transition ends at cke registered low
// [R14] running refresh extends entry transition
// [R15] turn-on bounded by async and sync delays
// [R16] turn-off bounded by async and sync delays
// [R17] sync latencies follow write latency
// [R18] sync change at write latency minus two
// [R19] hold lengths are four and six clocks
// [R20] one down-counter per pending hold
`timescale 1ns/1ps
`default_nettype none
module odtc_ctrl_end (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  odtc_link_if.ctrl        link
);
  import odtc_pkg::*;

  logic            odt_req,    next_odt_req;
  logic            cke,        next_cke;
  logic            dll_sel,    next_dll_sel;
  logic            nom_en,     next_nom_en;
  logic            wr_en,      next_wr_en;
  logic            dll_rst,    next_dll_rst;
  logic [3:0]      cas_write_latency,        next_cwl;
  logic [3:0]      al,         next_al;
  logic [3:0]      cl,         next_cl;
  logic            pend,       next_pend;
  odtc_cmd_t       pend_cmd,   next_pend_cmd;
  logic            pend_chop,  next_pend_chop;
  logic            odt,        next_odt;
  odtc_cmd_t       cmd_out,    next_cmd_out;
  logic            chop_out,   next_chop_out;
  logic            rd_ack,     next_rd_ack;
  logic [31:0]     rdata,      next_rdata;

  logic            short_idle;
  logic            write_idle;
  logic            rdblk_idle;
  logic            offw_idle;
  logic            short_load;
  logic            write_load;
  logic            rdblk_load;
  logic            offw_load;
  logic [7:0]      write_val;
  logic [7:0]      rdblk_val;
  logic [7:0]      offw_val;
  logic            term_used;
  logic            read_wait;
  logic            hold_ok;
  logic            want_odt;
  logic            issue;
  logic            cmd_wr;
  logic            ctrl_wr;
  logic            lat_wr;
  logic [31:0]     status;

  // one counter per pending hold; odt may fall only when the short and write counters are idle
  odtc_hold_timer u_short (                                   // see [R20]
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .load     (short_load),
    .load_val (SHORT_HOLD - 8'h01),
    .idle     (short_idle)
  );
  odtc_hold_timer u_write (                                   // see [R20]
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .load     (write_load),
    .load_val (write_val),
    .idle     (write_idle)
  );
  odtc_hold_timer u_rdblk (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .load     (rdblk_load),
    .load_val (rdblk_val),
    .idle     (rdblk_idle)
  );
  odtc_hold_timer u_offw (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .load     (offw_load),
    .load_val (offw_val),
    .idle     (offw_idle)
  );

  assign cmd_wr  = avs_write && (avs_address == REG_CMD);
  assign ctrl_wr = avs_write && (avs_address == REG_CTRL);
  assign lat_wr  = avs_write && (avs_address == REG_LAT);
  // reads take one wait cycle for registered data; a command waits for
  // the previous one to leave, which is how software is throttled
  assign avs_waitrequest = (avs_read && !rd_ack) || (cmd_wr && pend);

  always_comb begin
    term_used = nom_en || wr_en;
    read_wait = pend && (pend_cmd == ODTC_READ) && term_used;       // see [R5]
    hold_ok   = short_idle && write_idle;                           // see [R4]
    // a new assertion waits until the last read's postamble is over
    want_odt  = odt_req && rdblk_idle;                              // see [R6]
    next_odt  = odt;
    if (!odt && want_odt && !read_wait) begin
      next_odt = 1'b1;
    end else if (odt && (!want_odt || read_wait) && hold_ok) begin  // see [R1] [R3]
      next_odt = 1'b0;
    end
    // a read goes out only once termination has had time to switch off
    issue = pend && ((pend_cmd != ODTC_READ) || !term_used
                     || (!odt && offw_idle));                       // see [R5]
    short_load = !odt && next_odt;                                  // see [R19]
    write_load = issue && (pend_cmd == ODTC_WRITE) && next_odt;     // see [R2]
    write_val  = (pend_chop ? SHORT_HOLD : LONG_HOLD) - 8'h01;      // see [R19]
    offw_load  = odt && !next_odt;
    // off latency plus one clock covers the half-cycle skew margin
    offw_val   = 8'(odtc_sync_latency(cas_write_latency, al)) + 8'h01;           // see [R17]
    rdblk_load = issue && (pend_cmd == ODTC_READ);
    rdblk_val  = 8'(al) + 8'(cl) + (pend_chop ? BC4_CLK : BL8_CLK)
                 + POSTAMBLE;                                       // see [R6]

    next_cmd_out  = issue ? pend_cmd : ODTC_NOP;
    next_chop_out = issue ? pend_chop : 1'b0;
    next_pend      = pend && !issue;
    next_pend_cmd  = pend_cmd;
    next_pend_chop = pend_chop;
    if (cmd_wr && !pend) begin
      next_pend      = (avs_writedata[CMD_CODE +: 2] != 2'(ODTC_NOP));
      next_pend_cmd  = odtc_cmd_t'(avs_writedata[CMD_CODE +: 2]);
      next_pend_chop = avs_writedata[CMD_CHOP];
    end

    next_odt_req = odt_req;
    next_cke     = cke;
    next_dll_sel = dll_sel;
    next_nom_en  = nom_en;
    next_wr_en   = wr_en;
    next_dll_rst = 1'b0;
    if (ctrl_wr) begin
      next_odt_req = avs_writedata[CTRL_ODT];
      next_cke     = avs_writedata[CTRL_CKE];
      next_dll_sel = avs_writedata[CTRL_DLL_SEL];
      next_nom_en  = avs_writedata[CTRL_NOM_EN];
      next_wr_en   = avs_writedata[CTRL_WR_EN];
      next_dll_rst = avs_writedata[CTRL_DLL_RST];
    end
    next_cwl = cas_write_latency;
    next_al  = al;
    next_cl  = cl;
    if (lat_wr) begin
      next_cwl = avs_writedata[LAT_CWL +: 4];
      next_al  = avs_writedata[LAT_AL +: 4];
      next_cl  = avs_writedata[LAT_CL +: 4];
    end

    status = 32'h0000_0000;
    status[0] = odt;
    status[1] = cke;
    status[2] = !hold_ok;
    status[3] = !rdblk_idle;
    status[4] = pend;
    status[5] = !offw_idle;
    next_rd_ack = avs_read && !rd_ack;
    next_rdata  = rdata;
    if (avs_read && !rd_ack) begin
      case (avs_address)
        REG_CTRL: begin
          next_rdata = {26'h000_0000, 1'b0, wr_en, nom_en, dll_sel, cke, odt_req};
        end
        REG_LAT: begin
          next_rdata = {20'h0_0000, cl, al, cas_write_latency};
        end
        REG_STATUS: begin
          next_rdata = status;
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      odt_req   <= CTRL_RESET[CTRL_ODT];
      cke       <= CTRL_RESET[CTRL_CKE];
      dll_sel   <= CTRL_RESET[CTRL_DLL_SEL];
      nom_en    <= CTRL_RESET[CTRL_NOM_EN];
      wr_en     <= CTRL_RESET[CTRL_WR_EN];
      dll_rst   <= 1'b0;
      cas_write_latency       <= CWL_RESET;
      al        <= AL_RESET;
      cl        <= CL_RESET;
      pend      <= 1'b0;
      pend_cmd  <= ODTC_NOP;
      pend_chop <= 1'b0;
      odt       <= 1'b0;
      cmd_out   <= ODTC_NOP;
      chop_out  <= 1'b0;
      rd_ack    <= 1'b0;
      rdata     <= 32'h0000_0000;
    end else begin
      odt_req   <= next_odt_req;
      cke       <= next_cke;
      dll_sel   <= next_dll_sel;
      nom_en    <= next_nom_en;
      wr_en     <= next_wr_en;
      dll_rst   <= next_dll_rst;
      cas_write_latency       <= next_cwl;
      al        <= next_al;
      cl        <= next_cl;
      pend      <= next_pend;
      pend_cmd  <= next_pend_cmd;
      pend_chop <= next_pend_chop;
      odt       <= next_odt;
      cmd_out   <= next_cmd_out;
      chop_out  <= next_chop_out;
      rd_ack    <= next_rd_ack;
      rdata     <= next_rdata;
    end
  end

  assign avs_readdata    = rdata;
  assign link.odt        = odt;
  assign link.cke        = cke;
  assign link.cmd        = cmd_out;
  assign link.chop       = chop_out;
  assign link.cas_write_latency        = cas_write_latency;
  assign link.al         = al;
  assign link.dll_pd_sel = dll_sel;
  assign link.nom_en     = nom_en;
  assign link.wr_en      = wr_en;
  assign link.dll_reset  = dll_rst;
endmodule : odtc_ctrl_end
`default_nettype wire

// ==== odtc_dram_end.sv ====
// odtc_dram_end: memory device end; turns the registered odt pin into the
// internal termination state, synchronously or asynchronously.
// assumes the controller keeps its hold and read-gap duties.
`timescale 1ns/1ps
`default_nettype none
module odtc_dram_end #(
  parameter int REFRESH_CYCLES  = 8,
  parameter int DLL_LOCK_CYCLES = 512
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  odtc_link_if.dram link,
  output logic      term_on,
  output logic      term_async,
  output logic      entry_transition,
  output logic      refresh_busy
);
  import odtc_pkg::*;

  localparam int HIST_W = 32;

  logic [HIST_W-1:0] hist,     next_hist;
  logic              cke_q,    next_cke_q;
  logic [9:0]        rfc_cnt,  next_rfc_cnt;
  logic [9:0]        dll_cnt,  next_dll_cnt;
  logic              term,     next_term;
  logic              async_q,  next_async;
  logic              trans_q,  next_trans;
  logic [4:0]        lat;
  logic              rfc_run;
  logic              cke_fall;

  always_comb begin
    next_hist  = {hist[HIST_W-2:0], link.odt};
    next_cke_q = link.cke;
    rfc_run    = (rfc_cnt != 10'h000);
    cke_fall   = cke_q && !link.cke;
    next_rfc_cnt = rfc_run ? rfc_cnt - 10'h001 : rfc_cnt;
    if (link.cmd == ODTC_REFRESH) begin
      next_rfc_cnt = 10'(REFRESH_CYCLES);
    end
    next_dll_cnt = (dll_cnt != 10'h000) ? dll_cnt - 10'h001 : dll_cnt;
    if (link.dll_reset) begin
      next_dll_cnt = 10'(DLL_LOCK_CYCLES);                  // see [R8]
    end
    lat = odtc_sync_latency(link.cas_write_latency, link.al);             // see [R17] [R18]
    // the window opens only under the dll-off select, closes at cke low
    // or, if a refresh is still running, when that refresh completes
    next_trans = !link.dll_pd_sel
                 && (cke_fall || (trans_q && !cke_q && rfc_run)); // see [R12] [R13] [R14]
    // inside the window the synchronous path is kept unless a dll resync is running; its timing lies
    // within the allowed bracket of async delay and sync latency
    next_async = (next_dll_cnt != 10'h000)
                 || (!link.dll_pd_sel && !link.cke && !next_trans); // see [R7] [R8]
    if (!(link.nom_en || link.wr_en)) begin
      next_term = 1'b0;
    end else if (async_q) begin
      // one clock already exceeds the analog delay, and no additive latency
      next_term = hist[ASYNC_MIN_CYC-1];                    // see [R9] [R10] [R11]
    end else begin
      next_term = hist[lat - 5'h01];                        // see [R15] [R16] [R18]
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hist    <= '0;
      // matches the pin's idle level so release shows no false fall
      cke_q   <= 1'b1;
      rfc_cnt <= 10'h000;
      dll_cnt <= 10'h000;
      term    <= 1'b0;
      async_q <= 1'b0;
      trans_q <= 1'b0;
    end else begin
      hist    <= next_hist;
      cke_q   <= next_cke_q;
      rfc_cnt <= next_rfc_cnt;
      dll_cnt <= next_dll_cnt;
      term    <= next_term;
      async_q <= next_async;
      trans_q <= next_trans;
    end
  end

  assign term_on          = term;
  assign term_async       = async_q;
  assign entry_transition = trans_q;
  assign refresh_busy     = (rfc_cnt != 10'h000);
endmodule : odtc_dram_end
`default_nettype wire

// ==== odtc_link_sva.sv ====
// odtc_link_sva: timing checks on the pins between the two link ends.
// assumes one clk_sys domain and termination enables steady while odt moves.
`timescale 1ns/1ps
`default_nettype none
module odtc_link_sva (
  input wire logic                clk_sys,
  input wire logic                sys_rst,
  input wire logic                odt,
  input wire logic                cke,
  input wire odtc_pkg::odtc_cmd_t cmd,
  input wire logic                chop,
  input wire logic [3:0]          cas_write_latency,
  input wire logic [3:0]          al,
  input wire logic                dll_pd_sel,
  input wire logic                nom_en,
  input wire logic                wr_en,
  input wire logic                dll_reset,
  input wire logic                term_on,
  input wire logic                term_async,
  input wire logic                entry_transition
);
  import odtc_pkg::*;
  logic [31:0] hist;
  logic [31:0] next_hist;
  logic [4:0]  lat;
  logic        ten;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // odt as registered, newest first, so hist[lat] is the value lat+1 edges back
  always_comb next_hist = {hist[30:0], odt};
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) hist <= 32'h0000_0000;
    else hist <= next_hist;
  end
  assign lat = 5'(cas_write_latency) + 5'(al) - 5'h02;
  assign ten = nom_en | wr_en;

  property p_odt_min_high; $rose(odt) |-> odt [*4]; endproperty
  a_odt_min_high: assert property (p_odt_min_high)
    else $error("odt dropped before the short hold");
  property p_wr_bl8; (cmd == ODTC_WRITE) && odt && !chop |-> odt [*6]; endproperty
  a_wr_bl8: assert property (p_wr_bl8)
    else $error("odt dropped before the long hold after a write");
  property p_wr_bc4; (cmd == ODTC_WRITE) && odt && chop |-> odt [*4]; endproperty
  a_wr_bc4: assert property (p_wr_bc4)
    else $error("odt dropped before the short hold after a write");
  property p_read_off; (cmd == ODTC_READ) && ten |-> !odt && !term_on; endproperty
  a_read_off: assert property (p_read_off)
    else $error("termination still on at read");
  property p_read_gap; (cmd == ODTC_READ) && ten |-> !odt [*3]; endproperty
  a_read_gap: assert property (p_read_gap)
    else $error("odt raised inside the read burst");
  property p_sync_lat;
    !term_async && !$past(term_async) && $changed(term_on) && ten |-> term_on == hist[lat];
  endproperty
  a_sync_lat: assert property (p_sync_lat)
    else $error("synchronous termination off its latency");
  property p_async_on; term_async && $rose(odt) && ten |-> ##[1:3] term_on; endproperty
  a_async_on: assert property (p_async_on)
    else $error("asynchronous turn-on too late");
  property p_pde_start; $fell(cke) && !dll_pd_sel |-> ##[0:2] entry_transition; endproperty
  a_pde_start: assert property (p_pde_start)
    else $error("entry transition missing at cke low");
  property p_pde_sel; $rose(entry_transition) |-> !$past(dll_pd_sel); endproperty
  a_pde_sel: assert property (p_pde_sel)
    else $error("entry transition with dll kept on");
  property p_dll_resync; dll_reset |-> ##[1:3] term_async; endproperty
  a_dll_resync: assert property (p_dll_resync)
    else $error("odt not asynchronous during dll resync");
endmodule : odtc_link_sva
`default_nettype wire

// ==== testbench.sv ====
// testbench: orders the controller end over avalon-mm and watches both ends.
// assumes the device end is built with short refresh and dll lock counts.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import odtc_pkg::*;
  logic        clk_sys;
  logic        sys_rst;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        term_on;
  logic        term_async;
  logic        entry_transition;
  logic        refresh_busy;
  logic [31:0] rd;
  logic [3:0]  al_v;
  int          n_mismatch;
  int          comparisons;
  int          n;

  odtc_link_if link ();
  odtc_ctrl_end u_odtc_ctrl_end (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link.ctrl));
  odtc_dram_end #(.REFRESH_CYCLES(3), .DLL_LOCK_CYCLES(4)) u_odtc_dram_end (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .link(link.dram), .term_on(term_on),
    .term_async(term_async), .entry_transition(entry_transition),
    .refresh_busy(refresh_busy));
  odtc_link_sva u_odtc_link_sva (.clk_sys(clk_sys), .sys_rst(sys_rst), .odt(link.odt),
    .cke(link.cke), .cmd(link.cmd), .chop(link.chop), .cas_write_latency(link.cas_write_latency), .al(link.al),
    .dll_pd_sel(link.dll_pd_sel), .nom_en(link.nom_en), .wr_en(link.wr_en),
    .dll_reset(link.dll_reset), .term_on(term_on), .term_async(term_async),
    .entry_transition(entry_transition));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // entered just after a rising edge; the request stands until the rising
  // edge at which waitrequest is sampled low, and read data is taken there
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdc

  function automatic logic pick(input int k);
    case (k)
      0: pick = link.odt;
      1: pick = term_on;
      2: pick = term_async;
      3: pick = entry_transition;
      4: pick = refresh_busy;
      5: pick = (link.cmd === ODTC_READ);
      default: pick = (link.cmd === ODTC_WRITE);
    endcase
  endfunction : pick

  // n counts falling edges until the flag shows lvl; ends after a rising edge
  task automatic wait_flag(input int k, input logic lvl);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (pick(k) !== lvl && n < 400);
    // a flag that never arrives is a mismatch, not a pass by count
    chk(32'(pick(k)), 32'(lvl));
    @(posedge clk_sys);
  endtask : wait_flag

  task automatic probe(input logic lvl, input logic [31:0] exp);
    wait_flag(0, lvl);
    wait_flag(1, lvl);
    chk(n, exp);
  endtask : probe

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // the tests take some 210 clocks
  initial begin
    #2000000;
    n_mismatch++;
    conclude();
  end

  initial begin
    sys_rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    n_mismatch = 0;
    comparisons = 0;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rdc(REG_CTRL, CTRL_RESET);
    rdc(REG_LAT, 32'h0000_0605);
    rdc(REG_STATUS, 32'h0000_0002);
    rdc(4'h1, 32'h0000_0000);
    wr(REG_STATUS, 32'hffff_ffff);
    wr(4'h3, 32'hffff_ffff);
    rdc(REG_STATUS, 32'h0000_0002);
    rdc(REG_CTRL, CTRL_RESET);
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      al_v = (i == 0) ? 4'h3 : 4'h0;
      wr(REG_LAT, {20'h0_0000, 4'h6, al_v, 4'h5});
      wr(REG_CTRL, 32'h0000_000b);
      probe(1'b1, 32'(al_v) + 32'h0000_0004);
      wr(REG_CTRL, 32'h0000_000a);
      probe(1'b0, 32'(al_v) + 32'h0000_0004);
    end
    $display("test sync latency done");
    for (int i = 0; i < 2; i++) begin
      wr(REG_CTRL, 32'h0000_000b);
      wr(REG_CMD, 32'(i * 4 + 1));
      wr(REG_CTRL, 32'h0000_000a);
      wait_flag(0, 1'b0);
      chk(32'(n >= ((i == 0) ? 5 : 3)), 32'h0000_0001);
      repeat (8) @(posedge clk_sys);
    end
    $display("test write hold done");
    wr(REG_CMD, 32'h0000_0002);
    wr(REG_CTRL, 32'h0000_000b);
    wait_flag(0, 1'b1);
    chk(32'(n >= 8), 32'h0000_0001);
    wr(REG_CTRL, 32'h0000_000a);
    repeat (8) @(posedge clk_sys);
    $display("test read gap done");
    wr(REG_LAT, 32'h0000_0635);
    wr(REG_CMD, 32'h0000_0003);
    wr(REG_CTRL, 32'h0000_0008);
    wait_flag(3, 1'b1);
    chk(32'(n < 10), 32'h0000_0001);
    wait_flag(4, 1'b0);
    wait_flag(2, 1'b1);
    chk(32'(n < 20), 32'h0000_0001);
    wr(REG_CTRL, 32'h0000_0009);
    probe(1'b1, 32'h0000_0002);
    rdc(REG_STATUS, 32'h0000_0001);
    wr(REG_CTRL, 32'h0000_0008);
    probe(1'b0, 32'h0000_0002);
    wr(REG_CTRL, 32'h0000_000a);
    repeat (20) @(posedge clk_sys);
    wr(REG_CTRL, 32'h0000_000e);
    wr(REG_CTRL, 32'h0000_000c);
    repeat (4) @(posedge clk_sys);
    chk(32'(entry_transition), 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_000a);
    $display("test power-down entry done");
    wr(REG_CTRL, 32'h0000_002a);
    wait_flag(2, 1'b1);
    chk(32'(n < 4), 32'h0000_0001);
    wait_flag(2, 1'b0);
    rdc(REG_CTRL, 32'h0000_000a);
    $display("test dll reset done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
